// *** clock_sleep_map.vh ***
// register map, field positions, reset values and timing counts of the clock and sleep controller
`ifndef CLOCK_SLEEP_MAP_VH
`define CLOCK_SLEEP_MAP_VH

`define ADDR_W               4
`define CLOCK_DIVIDE_CONTROL 4'h0
`define SLEEP_CONTROL        4'h1
`define PCE_BIT              7
`define SLEEP_EN_BIT         0
`define SMODE_HI             3
`define SMODE_LO             1
`define PSEL_RESET_FAST      4'h0
`define PSEL_RESET_DIV8      4'h3
`define PSEL_MAX             4'h8
`define PCE_WINDOW           3'h4
`define WAKE_HALT            3'h4
`define SMODE_IDLE           3'h0
`define SMODE_ADC_NR         3'h1
`define SMODE_PDOWN          3'h2
`define SMODE_PSAVE          3'h3
`define SMODE_STANDBY        3'h6

`endif

// *** glitch_free_divider.v ***
// power-of-two clock-enable divider that only switches factor at a common boundary
`timescale 1ns/100ps
module glitch_free_divider (
  // clock and reset
  input  wire       CLK_I,
  input  wire       RESET_N_I,
  // control
  input  wire [3:0] SEL_I,
  // output enable pulse and divided clock level
  output wire       TICK_O,
  output reg        CLK_LEVEL_O
);

  reg  [7:0] count_reg;
  reg  [3:0] active_sel_reg;
  wire [7:0] next_count;

  // bit of the running count that gives the half period of the divided clock
  function [2:0] half_bit;
    input [3:0] sel;
    begin
      half_bit = sel[2:0] - 3'h1;
      if (sel[3])
        half_bit = 3'h7;
    end
  endfunction

  function [7:0] sel_mask;
    input [3:0] sel;
    begin
      sel_mask = (8'h01 << sel[2:0]) - 8'h01;
      if (sel[3])
        sel_mask = 8'hff;
    end
  endfunction

  assign next_count = count_reg + 8'h01;
  assign TICK_O     = ((count_reg & sel_mask(active_sel_reg)) == sel_mask(active_sel_reg));

  // new factor only taken when both old and new periods end, so no short pulse appears
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      count_reg      <= 8'h00;
      active_sel_reg <= 4'h0;
      CLK_LEVEL_O    <= 1'b0;
    end else begin
      count_reg <= next_count;
      if (TICK_O && ((count_reg & sel_mask(SEL_I)) == sel_mask(SEL_I))) begin
        active_sel_reg <= SEL_I;
        count_reg      <= 8'h00;
      end
      if (active_sel_reg == 4'h0)
        CLK_LEVEL_O <= ~CLK_LEVEL_O;
      else
        CLK_LEVEL_O <= count_reg[half_bit(active_sel_reg)];
    end
  end

endmodule // glitch_free_divider

// *** wake_halt_counter.v ***
// counts the stall cycles after a wake-up before the core is released
`include "clock_sleep_map.vh"
`timescale 1ns/100ps
module wake_halt_counter (
  // clock and reset
  input  wire       CLK_I,
  input  wire       RESET_N_I,
  // control
  input  wire       START_I,
  input  wire [7:0] EXTRA_I,
  // status
  output wire       BUSY_O,
  output wire       DONE_O
);

  reg [8:0] left_reg;

  assign BUSY_O = (left_reg != 9'h000);
  assign DONE_O = (left_reg == 9'h001);

  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I)
      left_reg <= 9'h000;
    else if (START_I)
      left_reg <= {1'b0, EXTRA_I} + {6'h00, `WAKE_HALT};
    else if (left_reg != 9'h000)
      left_reg <= left_reg - 9'h001;
  end

endmodule // wake_halt_counter

// *** clock_prescale_sleep_ctrl.v ***
// system clock prescaler, clock output, timer oscillator pin sharing and sleep control
`include "clock_sleep_map.vh"
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
// Function
// - fuse drives clock pin, also in reset
// - clock pin carries the prescaled clock, half of it at select zero
// - port G lines free only without oscillator
// - external clock frees only oscillator output line
// - prescaler divides io, adc, cpu, flash
// - select written only while change enable set
// - change enable set only with others zero
// - change enable clears after four cycles
// - select codes are powers of two
// - reset select from divide-by-eight fuse
// - any select up to eight accepted after reset
// - sleep needs enable bit and instruction
// - sleep mode field codes in bits 3..1
// - wake stalls four plus start-up cycles
// - register file and sram preserved
// - reset during sleep goes to vector
// - idle gates only cpu and flash
// - idle with adc on starts conversion
module clock_prescale_sleep_ctrl (
  // clock and reset
  input  wire                CLK_I,
  input  wire                RESET_N_I,
  // register port
  input  wire [`ADDR_W-1:0]  ADDR_I,
  input  wire [7:0]          WDATA_I,
  input  wire                WR_I,
  input  wire                RD_I,
  output reg  [7:0]          RDATA_O,
  // fuses
  input  wire                CLOCK_OUT_FUSE_I,
  input  wire                DIVIDE_BY_EIGHT_FUSE_I,
  // core and system events
  input  wire                SLEEP_INSTR_I,
  input  wire                WAKE_IRQ_I,
  input  wire [7:0]          STARTUP_CYCLES_I,
  input  wire                ADC_ENABLED_I,
  // asynchronous timer settings
  input  wire                TIMER_OSC_ENABLE_I,
  input  wire                ASYNC_EXTERNAL_CLOCK_SELECT_I,
  // port G line four and three, from the port logic
  input  wire                PORT_G_FOUR_OUT_I,
  input  wire                PORT_G_FOUR_OE_I,
  input  wire                PORT_G_THREE_OUT_I,
  input  wire                PORT_G_THREE_OE_I,
  // clock output pin, from the port logic
  input  wire                CLOCK_PIN_PORT_OUT_I,
  input  wire                CLOCK_PIN_PORT_OE_I,
  // clock enables per domain
  output wire                CPU_CLK_EN_O,
  output wire                FLASH_CLK_EN_O,
  output wire                IO_CLK_EN_O,
  output wire                ADC_CLK_EN_O,
  // sleep status
  output reg                 SLEEPING_O,
  output reg  [2:0]          SLEEP_MODE_O,
  output wire                CORE_HALT_O,
  output reg                 ADC_START_O,
  // pins
  output wire                TIMER_OSC_IN_PIN_OUT_O,
  output wire                TIMER_OSC_IN_PIN_OE_O,
  output wire                TIMER_OSC_OUT_PIN_OUT_O,
  output wire                TIMER_OSC_OUT_PIN_OE_O,
  output wire                CLOCK_OUTPUT_PIN_OUT_O,
  output wire                CLOCK_OUTPUT_PIN_OE_O
);

  //////////////////////////////////////////////////////////////////////////////
  // state
  localparam RUN   = 2'h0;
  localparam SLEEP = 2'h1;
  localparam WAKE  = 2'h2;

  reg  [3:0] prescale_select_reg;
  reg        prescale_change_enable_reg;
  reg  [2:0] pce_count_reg;
  reg        sleep_enable_bit_reg;
  reg  [2:0] sleep_mode_select_reg;
  reg  [1:0] state_reg;
  reg        fuse_loaded_reg;

  wire       tick;
  wire       div_level;
  wire       halt_busy;
  wire       halt_done;
  wire       wr_div;
  wire       wr_sleep;
  wire       idle_sleep;

  function valid_mode;
    input [2:0] mode;
    begin
      valid_mode = (mode == `SMODE_IDLE) || (mode == `SMODE_ADC_NR) || (mode == `SMODE_PDOWN) ||
                   (mode == `SMODE_PSAVE) || (mode == `SMODE_STANDBY);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // address decode
  assign wr_div   = WR_I && (ADDR_I == `CLOCK_DIVIDE_CONTROL);
  assign wr_sleep = WR_I && (ADDR_I == `SLEEP_CONTROL);

  //////////////////////////////////////////////////////////////////////////////
  // prescaler register
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      prescale_select_reg        <= `PSEL_RESET_FAST;
      prescale_change_enable_reg <= 1'b0;
      pce_count_reg              <= 3'h0;
      fuse_loaded_reg            <= 1'b0;
    end else begin
      // fuse sampled on the first edge after release, a constant is held in reset
      if (!fuse_loaded_reg) begin
        fuse_loaded_reg     <= 1'b1;
        prescale_select_reg <= DIVIDE_BY_EIGHT_FUSE_I ? `PSEL_RESET_DIV8 : `PSEL_RESET_FAST;
      end
      if (prescale_change_enable_reg) begin
        pce_count_reg <= pce_count_reg - 3'h1;
        if (pce_count_reg == 3'h1)
          prescale_change_enable_reg <= 1'b0;
      end
      if (wr_div) begin
        if (WDATA_I == 8'h80) begin
          if (!prescale_change_enable_reg) begin
            prescale_change_enable_reg <= 1'b1;
            pce_count_reg              <= `PCE_WINDOW;
          end
        end else if (prescale_change_enable_reg && !WDATA_I[`PCE_BIT]) begin
          // reserved codes are refused, the old factor stays
          if (WDATA_I[3:0] <= `PSEL_MAX)
            prescale_select_reg <= WDATA_I[3:0];
          prescale_change_enable_reg <= 1'b0;
          pce_count_reg              <= 3'h0;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sleep control register
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sleep_enable_bit_reg  <= 1'b0;
      sleep_mode_select_reg <= `SMODE_IDLE;
    end else if (wr_sleep) begin
      sleep_enable_bit_reg  <= WDATA_I[`SLEEP_EN_BIT];
      sleep_mode_select_reg <= WDATA_I[`SMODE_HI:`SMODE_LO];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read port, data one cycle after the strobe
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I)
      RDATA_O <= 8'h00;
    else if (RD_I) begin
      if (ADDR_I == `CLOCK_DIVIDE_CONTROL)
        RDATA_O <= {prescale_change_enable_reg, 3'h0, prescale_select_reg};
      else if (ADDR_I == `SLEEP_CONTROL)
        RDATA_O <= {4'h0, sleep_mode_select_reg, sleep_enable_bit_reg};
      else
        RDATA_O <= 8'h00;
    end else
      RDATA_O <= 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////////
  // divider and wake stall
  glitch_free_divider u_div (
    .CLK_I       (CLK_I),
    .RESET_N_I   (RESET_N_I),
    .SEL_I       (prescale_select_reg),
    .TICK_O      (tick),
    .CLK_LEVEL_O (div_level)
  );

  wake_halt_counter u_halt (
    .CLK_I     (CLK_I),
    .RESET_N_I (RESET_N_I),
    .START_I   ((state_reg == SLEEP) && WAKE_IRQ_I),
    .EXTRA_I   (STARTUP_CYCLES_I),
    .BUSY_O    (halt_busy),
    .DONE_O    (halt_done)
  );

  //////////////////////////////////////////////////////////////////////////////
  // sleep state machine; asynchronous reset returns to run, core restarts at vector
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state_reg    <= RUN;
      SLEEPING_O   <= 1'b0;
      SLEEP_MODE_O <= `SMODE_IDLE;
      ADC_START_O  <= 1'b0;
    end else begin
      ADC_START_O <= 1'b0;
      case (state_reg)
        RUN: begin
          if (SLEEP_INSTR_I && sleep_enable_bit_reg && valid_mode(sleep_mode_select_reg)) begin
            state_reg    <= SLEEP;
            SLEEPING_O   <= 1'b1;
            SLEEP_MODE_O <= sleep_mode_select_reg;
            ADC_START_O  <= ADC_ENABLED_I && ((sleep_mode_select_reg == `SMODE_IDLE) ||
                            (sleep_mode_select_reg == `SMODE_ADC_NR));
          end
        end
        SLEEP: begin
          if (WAKE_IRQ_I) begin
            state_reg  <= WAKE;
            SLEEPING_O <= 1'b0;
          end
        end
        WAKE: begin
          if (halt_done)
            state_reg <= RUN;
        end
        default: state_reg <= RUN;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // clock enables; only gating, nothing is cleared, so core memories keep their data
  assign idle_sleep     = (state_reg == SLEEP);
  assign CORE_HALT_O    = (state_reg != RUN) || halt_busy;
  assign CPU_CLK_EN_O   = tick && !CORE_HALT_O;
  assign FLASH_CLK_EN_O = tick && !CORE_HALT_O;
  assign IO_CLK_EN_O    = tick && !(idle_sleep && (SLEEP_MODE_O != `SMODE_IDLE));
  assign ADC_CLK_EN_O   = tick && !(idle_sleep && (SLEEP_MODE_O != `SMODE_IDLE) &&
                          (SLEEP_MODE_O != `SMODE_ADC_NR));

  //////////////////////////////////////////////////////////////////////////////
  // pins
  assign CLOCK_OUTPUT_PIN_OUT_O  = CLOCK_OUT_FUSE_I ? div_level : CLOCK_PIN_PORT_OUT_I;
  assign CLOCK_OUTPUT_PIN_OE_O   = CLOCK_OUT_FUSE_I | CLOCK_PIN_PORT_OE_I;
  // oscillator in pin is lost also for external clock; out pin only for the crystal
  assign TIMER_OSC_IN_PIN_OUT_O  = PORT_G_FOUR_OUT_I;
  assign TIMER_OSC_IN_PIN_OE_O   = PORT_G_FOUR_OE_I && !TIMER_OSC_ENABLE_I &&
                                   !ASYNC_EXTERNAL_CLOCK_SELECT_I;
  assign TIMER_OSC_OUT_PIN_OUT_O = PORT_G_THREE_OUT_I;
  assign TIMER_OSC_OUT_PIN_OE_O  = PORT_G_THREE_OE_I && (!TIMER_OSC_ENABLE_I ||
                                   ASYNC_EXTERNAL_CLOCK_SELECT_I);

endmodule // clock_prescale_sleep_ctrl

// *** clock_sleep_checker_asserts.sv ***
// port-level assertion checker for the clock prescaler and sleep controller
`include "clock_sleep_map.vh"
`timescale 1ns/100ps
module clock_sleep_checker (
  // clock, reset, register port
  input wire       CLK_I,
  input wire       RESET_N_I,
  input wire [3:0] ADDR_I,
  input wire [7:0] WDATA_I,
  input wire       WR_I,
  // fuse, events, pin requests
  input wire       CLOCK_OUT_FUSE_I,
  input wire       SLEEP_INSTR_I,
  input wire       WAKE_IRQ_I,
  input wire       ADC_ENABLED_I,
  input wire       TIMER_OSC_ENABLE_I,
  input wire       ASYNC_EXTERNAL_CLOCK_SELECT_I,
  input wire       PORT_G_FOUR_OE_I,
  input wire       PORT_G_THREE_OE_I,
  // design outputs
  input wire       CPU_CLK_EN_O,
  input wire       FLASH_CLK_EN_O,
  input wire       IO_CLK_EN_O,
  input wire       ADC_CLK_EN_O,
  input wire       SLEEPING_O,
  input wire [2:0] SLEEP_MODE_O,
  input wire       CORE_HALT_O,
  input wire       ADC_START_O,
  input wire       TIMER_OSC_IN_PIN_OE_O,
  input wire       TIMER_OSC_OUT_PIN_OE_O,
  input wire       CLOCK_OUTPUT_PIN_OE_O
);
  reg        se_reg;
  reg  [2:0] mode_reg;
  wire       mode_ok = !mode_reg[2] || mode_reg == `SMODE_STANDBY;
  // software copy of sleep_control, rebuilt from the write strobes
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      se_reg   <= 1'b0;
      mode_reg <= 3'h0;
    end else if (WR_I && ADDR_I == `SLEEP_CONTROL) begin
      se_reg   <= WDATA_I[`SLEEP_EN_BIT];
      mode_reg <= WDATA_I[`SMODE_HI:`SMODE_LO];
    end
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  clk_pin_fuse_a: assert property (CLOCK_OUT_FUSE_I |-> CLOCK_OUTPUT_PIN_OE_O)
    else $error("clock pin not driven");
  osc_pins_a: assert property (TIMER_OSC_ENABLE_I && !ASYNC_EXTERNAL_CLOCK_SELECT_I
    |-> !TIMER_OSC_IN_PIN_OE_O && !TIMER_OSC_OUT_PIN_OE_O) else $error("port drives oscillator pin");
  port_lines_a: assert property (!TIMER_OSC_ENABLE_I && !ASYNC_EXTERNAL_CLOCK_SELECT_I
    |-> TIMER_OSC_IN_PIN_OE_O == PORT_G_FOUR_OE_I && TIMER_OSC_OUT_PIN_OE_O == PORT_G_THREE_OE_I)
    else $error("port line not passed");
  ext_clock_a: assert property (ASYNC_EXTERNAL_CLOCK_SELECT_I
    |-> !TIMER_OSC_IN_PIN_OE_O && TIMER_OSC_OUT_PIN_OE_O == PORT_G_THREE_OE_I) else $error("ext clock pins");
  sleep_entry_a: assert property (SLEEP_INSTR_I && se_reg && mode_ok && !CORE_HALT_O && !WAKE_IRQ_I
    |=> SLEEPING_O && SLEEP_MODE_O == $past(mode_reg)) else $error("sleep not entered");
  no_sleep_a: assert property (SLEEP_INSTR_I && !(se_reg && mode_ok) && !SLEEPING_O
    |=> !SLEEPING_O) else $error("sleep entered wrongly");
  wake_halt_a: assert property (SLEEPING_O && WAKE_IRQ_I |=> !SLEEPING_O ##0 CORE_HALT_O [*4])
    else $error("wake stall too short");
  idle_gate_a: assert property (SLEEPING_O && SLEEP_MODE_O == `SMODE_IDLE
    |-> !CPU_CLK_EN_O && !FLASH_CLK_EN_O) else $error("cpu clock runs in idle");
  adc_start_a: assert property ($rose(SLEEPING_O)
    |-> ADC_START_O == (ADC_ENABLED_I && SLEEP_MODE_O <= `SMODE_ADC_NR)) else $error("adc start wrong");
  io_pair_a: assert property (CPU_CLK_EN_O |-> IO_CLK_EN_O && ADC_CLK_EN_O)
    else $error("domain enables differ");
endmodule // clock_sleep_checker
bind clock_prescale_sleep_ctrl clock_sleep_checker checker_i (.*);

// *** tb.sv ***
// self-checking bench for the clock prescaler and sleep controller
`include "clock_sleep_map.vh"
`timescale 1ns/100ps
module tb;
  reg        CLK_I, RESET_N_I, WR_I, RD_I, CLOCK_OUT_FUSE_I, DIVIDE_BY_EIGHT_FUSE_I, SLEEP_INSTR_I, WAKE_IRQ_I;
  reg        ADC_ENABLED_I, TIMER_OSC_ENABLE_I, ASYNC_EXTERNAL_CLOCK_SELECT_I, CLOCK_PIN_PORT_OUT_I;
  reg        PORT_G_FOUR_OUT_I, PORT_G_FOUR_OE_I, PORT_G_THREE_OUT_I, PORT_G_THREE_OE_I, CLOCK_PIN_PORT_OE_I;
  reg  [3:0] ADDR_I;
  reg  [7:0] WDATA_I, STARTUP_CYCLES_I, rd_val;
  wire [7:0] RDATA_O;
  wire [2:0] SLEEP_MODE_O;
  wire       CPU_CLK_EN_O, FLASH_CLK_EN_O, IO_CLK_EN_O, ADC_CLK_EN_O, SLEEPING_O, CORE_HALT_O, ADC_START_O;
  wire       TIMER_OSC_IN_PIN_OUT_O, TIMER_OSC_IN_PIN_OE_O, TIMER_OSC_OUT_PIN_OUT_O, TIMER_OSC_OUT_PIN_OE_O;
  wire       CLOCK_OUTPUT_PIN_OUT_O, CLOCK_OUTPUT_PIN_OE_O;
  integer    fails, num_checks, i, n;
  integer    cnt [0:4];
  clock_prescale_sleep_ctrl DUT (.*);
  initial begin
    CLK_I = 1'b0;
    forever #25 CLK_I = ~CLK_I;
  end
  //////////////////////////////////////////////////////////////////////////////
  task check(input [7:0] seen, input [7:0] want);
    begin
      num_checks = num_checks + 1;
      if (seen !== want) begin
        fails = fails + 1;
        $display("ERROR at %0t: saw %h expected %h", $time, seen, want);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge CLK_I);
      ADDR_I  <= a;
      WDATA_I <= d;
      WR_I    <= 1'b1;
      @(posedge CLK_I);
      WR_I    <= 1'b0;
    end
  endtask
  task rd(input [3:0] a);
    begin
      @(posedge CLK_I);
      ADDR_I <= a;
      RD_I   <= 1'b1;
      @(posedge CLK_I);
      RD_I   <= 1'b0;
      #1 rd_val = RDATA_O;
    end
  endtask
  // enable write, gap idle edges, then the select write; gap 3 lands past the window
  // wake line held low through the sequence; async timer clock is never driven
  task chg(input [7:0] code, input integer gap);
    begin
      wr(`CLOCK_DIVIDE_CONTROL, 8'h80);
      repeat (gap) @(posedge CLK_I);
      wr(`CLOCK_DIVIDE_CONTROL, code);
      rd(`CLOCK_DIVIDE_CONTROL);
    end
  endtask
  task pulse(input wake);
    begin
      @(posedge CLK_I);
      SLEEP_INSTR_I <= !wake;
      WAKE_IRQ_I    <= wake;
      @(posedge CLK_I);
      SLEEP_INSTR_I <= 1'b0;
      WAKE_IRQ_I    <= 1'b0;
      #1;
    end
  endtask
  task do_reset(input div8);
    begin
      @(posedge CLK_I);
      RESET_N_I              <= 1'b0;
      DIVIDE_BY_EIGHT_FUSE_I <= div8;
      repeat (12) @(posedge CLK_I);
      #1 check(CLOCK_OUTPUT_PIN_OE_O, 1'b1);
      check(SLEEPING_O, 1'b0);
      @(posedge CLK_I);
      RESET_N_I <= 1'b1;
      rd(`CLOCK_DIVIDE_CONTROL);
      check(rd_val, div8 ? `PSEL_RESET_DIV8 : `PSEL_RESET_FAST);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task test_prescale;
    begin
      for (i = 0; i <= 8; i = i + 1) begin
        chg(i[7:0], i % 2);
        check(rd_val, i[7:0]);
      end
      chg(8'h09, 0);
      check(rd_val, 8'h08);
      chg(8'h02, 3);
      check(rd_val, 8'h08);
      wr(`CLOCK_DIVIDE_CONTROL, 8'h80);
      @(posedge CLK_I);
      chg(8'h02, 0);
      check(rd_val, 8'h08);
      wr(`CLOCK_DIVIDE_CONTROL, 8'h80);
      rd(`CLOCK_DIVIDE_CONTROL);
      check(rd_val, 8'h88);
      @(posedge CLK_I);
      wr(`CLOCK_DIVIDE_CONTROL, 8'h05);
      rd(`CLOCK_DIVIDE_CONTROL);
      check(rd_val, 8'h08);
      wr(`CLOCK_DIVIDE_CONTROL, 8'h81);
      wr(`CLOCK_DIVIDE_CONTROL, 8'h05);
      rd(`CLOCK_DIVIDE_CONTROL);
      check(rd_val, 8'h08);
      $display("prescale test done");
    end
  endtask
  task test_divider;
    reg last;
    begin
      chg(8'h02, 0);
      // the divider may wait up to a full old period before switching
      repeat (300) @(posedge CLK_I);
      for (i = 0; i < 5; i = i + 1) cnt[i] = 0;
      #1 last = CLOCK_OUTPUT_PIN_OUT_O;
      repeat (64) begin
        @(posedge CLK_I);
        #1 cnt[0] = cnt[0] + IO_CLK_EN_O;
        cnt[1] = cnt[1] + CPU_CLK_EN_O;
        cnt[2] = cnt[2] + FLASH_CLK_EN_O;
        cnt[3] = cnt[3] + ADC_CLK_EN_O;
        cnt[4] = cnt[4] + (CLOCK_OUTPUT_PIN_OUT_O && !last);
        last = CLOCK_OUTPUT_PIN_OUT_O;
      end
      for (i = 0; i < 4; i = i + 1) check(cnt[i][7:0], 8'd16);
      check(cnt[4][7:0], 8'd16);
      $display("divider test done");
    end
  endtask
  task test_sleep;
    begin
      wr(`SLEEP_CONTROL, 8'h00);
      pulse(1'b0);
      check(SLEEPING_O, 1'b0);
      wr(`SLEEP_CONTROL, 8'h01);
      pulse(1'b0);
      check(SLEEPING_O, 1'b1);
      check(ADC_START_O, 1'b1);
      check(SLEEP_MODE_O, `SMODE_IDLE);
      cnt[0] = 0;
      cnt[1] = 0;
      repeat (8) begin
        @(posedge CLK_I);
        #1 cnt[0] = cnt[0] + IO_CLK_EN_O;
        cnt[1] = cnt[1] + CPU_CLK_EN_O;
      end
      check(cnt[0][7:0], 8'd2);
      check(cnt[1][7:0], 8'd0);
      pulse(1'b1);
      check(SLEEPING_O, 1'b0);
      n = 0;
      while (CORE_HALT_O === 1'b1 && n < 20) begin
        n = n + 1;
        @(posedge CLK_I);
        #1;
      end
      check(n[7:0], 8'd4 + STARTUP_CYCLES_I);
      wr(`SLEEP_CONTROL, 8'h00);
      rd(`CLOCK_DIVIDE_CONTROL);
      check(rd_val, 8'h02);
      for (i = 1; i < 8; i = i + 1) begin
        wr(`SLEEP_CONTROL, {4'h0, i[2:0], 1'b1});
        pulse(1'b0);
        check(SLEEPING_O, !i[2] || i == 6);
        check(ADC_START_O, i == 1);
        pulse(1'b1);
        repeat (12) @(posedge CLK_I);
      end
      wr(`SLEEP_CONTROL, 8'h05);
      pulse(1'b0);
      do_reset(1'b0);
      $display("sleep test done");
    end
  endtask
  task test_pins;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        @(posedge CLK_I);
        TIMER_OSC_ENABLE_I            <= i[0];
        ASYNC_EXTERNAL_CLOCK_SELECT_I <= i[1];
        @(posedge CLK_I);
        #1 check(TIMER_OSC_IN_PIN_OE_O, !i[0] && !i[1]);
        check(TIMER_OSC_OUT_PIN_OE_O, !i[0] || i[1]);
      end
      CLOCK_OUT_FUSE_I <= 1'b0;
      @(posedge CLK_I);
      #1 check(CLOCK_OUTPUT_PIN_OE_O, 1'b0);
      $display("pin test done");
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    fails = fails + 1;
    complete_run;
  end
  initial begin
    {RESET_N_I, WR_I, RD_I, SLEEP_INSTR_I, WAKE_IRQ_I, TIMER_OSC_ENABLE_I, ASYNC_EXTERNAL_CLOCK_SELECT_I} = 7'h00;
    {CLOCK_OUT_FUSE_I, DIVIDE_BY_EIGHT_FUSE_I, ADC_ENABLED_I, CLOCK_PIN_PORT_OE_I} = 4'he;
    {PORT_G_FOUR_OUT_I, PORT_G_FOUR_OE_I, PORT_G_THREE_OUT_I, PORT_G_THREE_OE_I, CLOCK_PIN_PORT_OUT_I} = 5'h1f;
    ADDR_I           = 4'h0;
    WDATA_I          = 8'h00;
    STARTUP_CYCLES_I = 8'h03;
    fails            = 0;
    num_checks       = 0;
    do_reset(1'b0);
    do_reset(1'b1);
    test_prescale;
    test_divider;
    chg(8'h02, 0);
    test_sleep;
    test_pins;
    complete_run;
  end
endmodule // tb
